// *** logic/gcr_regs.sv ***
// Global control, counter access and power event register bank
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module gcr_regs
	import gcr_pkg::*;
#(
	parameter int unsigned WAKE_CYC = WAKE_CYC_DFLT
) (
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	input  wire logic        por_rst_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic        mib_evt_valid_in,
	input  wire logic [4:0]  mib_evt_index_in,
	output logic             mib_evt_ready_out,
	input  wire logic        link_in,
	input  wire logic        act_in,
	input  wire logic        full_dpx_in,
	input  wire logic        col_in,
	input  wire logic        speed100_in,
	output logic             port_led_three_out,
	output logic             port_led_two_out,
	output logic             port_led_one_out,
	output logic             port_led_zero_out,
	input  wire logic [3:0]  wake_evt_in,
	input  wire logic        energy_in,
	input  wire logic        low_power_in,
	input  wire logic        clocks_ready_in,
	output logic             power_event_output_out,
	output logic             wake_req_out,
	output logic             irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Storage

	logic [15:0]        global_ctrl;
	logic [15:0]        ind_cmd;
	logic [15:0]        data_lo;
	logic [15:0]        data_hi;
	logic [15:0]        pwr_evt;
	logic [3:0]         wake_ind;
	logic [IRQ_W-1:0]   irq_stat;
	logic [IRQ_W-1:0]   irq_mask;
	gcr_seq_t           seq;
	gcr_seq_t           next_seq;
	logic               cmd_pend;
	logic [MIB_AW-1:0]  cmd_addr;
	logic [MIB_AW-1:0]  op_addr;
	logic [MIB_AW-1:0]  init_addr;
	logic               cmd_take;
	logic               inc_take;
	logic               cmd_done;
	logic [15:0]        next_rdata;
	logic [IRQ_W-1:0]   irq_set;
	logic               wr_gcr;
	logic               wr_iac;
	logic               wr_lo;
	logic               wr_hi;
	logic               wr_pme;
	logic               wr_stat;
	logic               wr_mask;
	logic               link_act;

	gcr_mib_if mib ();

	////////////////////////////////////////////////////////////////////////
	// Write decode

	// One strobe per writable register
	assign wr_gcr  = reg_wr_in & (reg_addr_in == OFS_GLOBAL_CTRL);
	assign wr_iac  = reg_wr_in & (reg_addr_in == OFS_IND_CMD);
	assign wr_lo   = reg_wr_in & (reg_addr_in == OFS_DATA_LO);
	assign wr_hi   = reg_wr_in & (reg_addr_in == OFS_DATA_HI);
	assign wr_pme  = reg_wr_in & (reg_addr_in == OFS_PWR_EVT);
	assign wr_stat = reg_wr_in & (reg_addr_in == OFS_IRQ_STAT);
	assign wr_mask = reg_wr_in & (reg_addr_in == OFS_IRQ_MASK);

	// Global control, plain storage
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			global_ctrl <= GCR_RST;
		end else if (wr_gcr) begin
			global_ctrl <= reg_wdata_in;
		end
	end

	// Indirect command register keeps the last written value
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ind_cmd <= IAC_RST;
		end else if (wr_iac) begin
			ind_cmd <= reg_wdata_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indirect command launch

	// Pending read command, one deep; a new write replaces it
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cmd_pend <= 1'b0;
			cmd_addr <= '0;
		end else if (wr_iac) begin
			cmd_pend <= reg_wdata_in[IAC_READ_EN]
				& (reg_wdata_in[IAC_TSEL_HI:IAC_TSEL_LO] == TSEL_MIB);
			cmd_addr <= reg_wdata_in[IAC_ADDR_HI:0];
		end else if (cmd_take) begin
			cmd_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter sequencer

	// Commands beat increments; nothing starts while busy
	assign cmd_take          = (seq == SEQ_IDLE) & cmd_pend & ~wr_iac;
	assign inc_take          = (seq == SEQ_IDLE) & ~cmd_take & mib_evt_valid_in;
	assign mib_evt_ready_out = (seq == SEQ_IDLE) & ~cmd_take;
	assign cmd_done          = (seq == SEQ_CMD);

	// Next state
	always_comb begin
		next_seq = seq;
		case (seq)
			SEQ_IDLE: begin
				if (cmd_take) begin
					next_seq = SEQ_CMD;
				end else if (inc_take) begin
					next_seq = SEQ_INC;
				end
			end
			SEQ_CMD: begin
				next_seq = SEQ_IDLE;
			end
			SEQ_INC: begin
				next_seq = SEQ_IDLE;
			end
			SEQ_INIT: begin
				if (init_addr == 5'h1F) begin
					next_seq = SEQ_IDLE;
				end
			end
			default: begin
				next_seq = SEQ_IDLE;
			end
		endcase
	end

	// State, clearing sweep after reset
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			seq <= SEQ_INIT;
		end else begin
			seq <= next_seq;
		end
	end

	// Sweep address
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			init_addr <= '0;
		end else if (seq == SEQ_INIT) begin
			init_addr <= init_addr + 1'b1;
		end
	end

	// Address of the access in flight
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			op_addr <= '0;
		end else if (cmd_take) begin
			op_addr <= cmd_addr;
		end else if (inc_take) begin
			op_addr <= mib_evt_index_in;
		end
	end

	// Memory port: read in idle, write back one cycle later
	always_comb begin
		mib.rd_en = cmd_take | inc_take;
		mib.wr_en = 1'b0;
		mib.addr  = cmd_take ? cmd_addr : mib_evt_index_in;
		mib.wdata = 32'h00000000;
		case (seq)
			SEQ_CMD: begin
				mib.wr_en = 1'b1;
				mib.addr  = op_addr;
			end
			SEQ_INC: begin
				mib.wr_en = 1'b1;
				mib.addr  = op_addr;
				mib.wdata = mib.rdata + 32'h00000001;
			end
			SEQ_INIT: begin
				mib.wr_en = 1'b1;
				mib.addr  = init_addr;
			end
			default: begin
				mib.wr_en = 1'b0;
			end
		endcase
	end

	gcr_mib_mem u_mem (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.mib        (mib.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// Indirect data words

	// Counter value lands in the data words; capture beats a bus write
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			data_lo <= DATA_RST;
			data_hi <= DATA_RST;
		end else begin
			if (cmd_done) begin
				data_lo <= mib.rdata[15:0];
				data_hi <= mib.rdata[31:16];
			end else begin
				if (wr_lo) begin
					data_lo <= reg_wdata_in;
				end
				if (wr_hi) begin
					data_hi <= reg_wdata_in;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power event control

	// Writable bits only
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pwr_evt <= PMEC_RST;
		end else if (wr_pme) begin
			pwr_evt <= reg_wdata_in & PMEC_RW_MASK;
		end
	end

	// Wake indication: only power-up clears it besides write-one
	always_ff @(posedge clock_in or posedge por_rst_in) begin
		if (por_rst_in) begin
			wake_ind <= 4'h0;
		end else begin
			wake_ind <= (wake_ind & ~({4{wr_pme}} & reg_wdata_in[PMEC_IND_LO+3:PMEC_IND_LO]))
				| wake_evt_in;
		end
	end

	gcr_pme #(
		.WAKE_CYC (WAKE_CYC)
	) u_pme (
		.clock_in        (clock_in),
		.sys_rst_in      (sys_rst_in),
		.evt_en_in       (pwr_evt[PMEC_EN_LO+3:PMEC_EN_LO]),
		.evt_ind_in      (wake_ind),
		.polarity_in     (pwr_evt[PMEC_POL]),
		.delay_en_in     (pwr_evt[PMEC_DLY]),
		.auto_wake_in    (pwr_evt[PMEC_AUTO]),
		.wake_norm_in    (pwr_evt[PMEC_WAKE_NORM]),
		.pm_mode_in      (pwr_evt[1:0]),
		.clocks_ready_in (clocks_ready_in),
		.low_power_in    (low_power_in),
		.energy_in       (energy_in),
		.pme_out         (power_event_output_out),
		.wake_req_out    (wake_req_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Port LEDs

	// Link lamp blinks off on activity in selections 0 and 1
	assign link_act = link_in & ~act_in;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{port_led_three_out, port_led_two_out, port_led_one_out, port_led_zero_out} <= 4'h0;
		end else begin
			case ({global_ctrl[GCR_LEDSEL_HI], global_ctrl[GCR_LEDSEL_LO]})
				2'b00: begin
					port_led_three_out <= 1'b0;
					port_led_two_out   <= link_act;
					port_led_one_out   <= full_dpx_in | col_in;
					port_led_zero_out  <= speed100_in;
				end
				2'b01: begin
					port_led_three_out <= 1'b0;
					port_led_two_out   <= link_act & speed100_in;
					port_led_one_out   <= link_act & ~speed100_in;
					port_led_zero_out  <= full_dpx_in;
				end
				2'b10: begin
					port_led_three_out <= act_in;
					port_led_two_out   <= link_in;
					port_led_one_out   <= full_dpx_in | col_in;
					port_led_zero_out  <= speed100_in;
				end
				default: begin
					{port_led_three_out, port_led_two_out, port_led_one_out, port_led_zero_out} <= 4'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts

	// Sticky events
	assign irq_set[IRQ_MIB_DONE] = cmd_done;
	assign irq_set[IRQ_WAKE_EVT] = |wake_evt_in;
	assign irq_set[IRQ_WAKE_REQ] = wake_req_out;

	// Write-one clear, set wins
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~({IRQ_W{wr_stat}} & reg_wdata_in[IRQ_W-1:0])) | irq_set;
		end
	end

	// Mask
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= reg_wdata_in[IRQ_W-1:0];
		end
	end

	assign irq_out = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Read mux, unmapped reads zero
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr_in)
			OFS_CHIP_ID:     next_rdata = {FAMILY_ID, CHIP_ID, REV_ID, 1'b0};
			OFS_GLOBAL_CTRL: next_rdata = global_ctrl;
			OFS_IND_CMD:     next_rdata = ind_cmd;
			OFS_DATA_LO:     next_rdata = data_lo;
			OFS_DATA_HI:     next_rdata = data_hi;
			OFS_PWR_EVT:     next_rdata = pwr_evt | {10'h000, wake_ind, 2'h0};
			OFS_IRQ_STAT:    next_rdata = {13'h0000, irq_stat};
			OFS_IRQ_MASK:    next_rdata = {13'h0000, irq_mask};
			default:         next_rdata = 16'h0000;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= next_rdata;
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

endmodule
`default_nettype wire

// *** inc/gcr_pkg.sv ***
// Constants, field positions and types of the global control register bank
package gcr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the plain register port
	localparam logic [7:0] OFS_CHIP_ID     = 8'hC0;
	localparam logic [7:0] OFS_GLOBAL_CTRL = 8'hC6;
	localparam logic [7:0] OFS_IND_CMD     = 8'hC8;
	localparam logic [7:0] OFS_DATA_LO     = 8'hD0;
	localparam logic [7:0] OFS_DATA_HI     = 8'hD2;
	localparam logic [7:0] OFS_PWR_EVT     = 8'hD4;
	localparam logic [7:0] OFS_IRQ_STAT    = 8'hE0;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'hE2;

	// Identification values, arbitrary
	localparam logic [7:0] FAMILY_ID = 8'h5A;
	localparam logic [3:0] CHIP_ID   = 4'h3;
	localparam logic [2:0] REV_ID    = 3'h2;

	////////////////////////////////////////////////////////////////////////
	// Global control fields
	localparam logic [15:0] GCR_RST        = 16'h0835;
	localparam int          GCR_LEDSEL_HI  = 15;
	localparam int          GCR_LEDSEL_LO  = 9;

	// Indirect command fields
	localparam logic [15:0] IAC_RST        = 16'h0000;
	localparam int          IAC_READ_EN    = 12;
	localparam int          IAC_TSEL_HI    = 11;
	localparam int          IAC_TSEL_LO    = 10;
	localparam logic [1:0]  TSEL_MIB       = 2'h3;
	localparam int          IAC_ADDR_HI    = 4;
	localparam logic [15:0] DATA_RST       = 16'h0000;

	// Power event control fields
	localparam logic [15:0] PMEC_RST       = 16'h0000;
	localparam logic [15:0] PMEC_RW_MASK   = 16'h5FC3;
	localparam int          PMEC_DLY       = 14;
	localparam int          PMEC_POL       = 12;
	localparam int          PMEC_EN_LO     = 8;
	localparam int          PMEC_AUTO      = 7;
	localparam int          PMEC_WAKE_NORM = 6;
	localparam int          PMEC_IND_LO    = 2;
	localparam logic [1:0]  PM_MODE_ENERGY = 2'h1;

	////////////////////////////////////////////////////////////////////////
	// Wake time: 16 ms unit times 8 units at 100 MHz
	localparam int          CLK_MHZ        = 100;
	localparam int          WAKE_UNIT_MS   = 16;
	localparam int          WAKE_UNITS     = 8;
	localparam int          WAKE_CYC_DFLT  = WAKE_UNIT_MS * WAKE_UNITS * CLK_MHZ * 1000;
	localparam int          WAKE_CW        = 24;

	// Interrupt status bits
	localparam int          IRQ_MIB_DONE   = 0;
	localparam int          IRQ_WAKE_EVT   = 1;
	localparam int          IRQ_WAKE_REQ   = 2;
	localparam int          IRQ_W          = 3;

	// Counter memory shape
	localparam int          MIB_AW         = 5;
	localparam int          MIB_DW         = 32;
	localparam int          MIB_DEPTH      = 32;

	// Counter access sequencer
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_CMD  = 2'b01,
		SEQ_INC  = 2'b10,
		SEQ_INIT = 2'b11
	} gcr_seq_t;

endpackage

// *** inc/gcr_mib_if.sv ***
// Port bundle between the sequencer and the counter memory
`timescale 1ns/1ns
`default_nettype none
interface gcr_mib_if;
	import gcr_pkg::*;
	logic              rd_en;
	logic              wr_en;
	logic [MIB_AW-1:0] addr;
	logic [MIB_DW-1:0] wdata;
	logic [MIB_DW-1:0] rdata;
	modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
	modport mem  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** logic/gcr_mib_mem.sv ***
// Statistics counter memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module gcr_mib_mem
	import gcr_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	gcr_mib_if.mem    mib
);

	logic [MIB_DW-1:0] store [MIB_DEPTH];

	// Write port
	always_ff @(posedge clock_in) begin
		if (mib.wr_en) begin
			store[mib.addr] <= mib.wdata;
		end
	end

	// Registered read port
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mib.rdata <= 32'h00000000;
		end else if (mib.rd_en) begin
			mib.rdata <= store[mib.addr];
		end
	end

endmodule
`default_nettype wire

// *** logic/gcr_pme.sv ***
// Power event pin drive and energy-detect wake timer
`timescale 1ns/1ns
`default_nettype none
module gcr_pme
	import gcr_pkg::*;
#(
	parameter int unsigned WAKE_CYC = WAKE_CYC_DFLT
) (
	input  wire logic       clock_in,
	input  wire logic       sys_rst_in,
	input  wire logic [3:0] evt_en_in,
	input  wire logic [3:0] evt_ind_in,
	input  wire logic       polarity_in,
	input  wire logic       delay_en_in,
	input  wire logic       auto_wake_in,
	input  wire logic       wake_norm_in,
	input  wire logic [1:0] pm_mode_in,
	input  wire logic       clocks_ready_in,
	input  wire logic       low_power_in,
	input  wire logic       energy_in,
	output logic            pme_out,
	output logic            wake_req_out
);

	localparam logic [WAKE_CW-1:0] WAKE_LAST = WAKE_CW'(WAKE_CYC);

	logic               asserted;
	logic               hold_off;
	logic               next_pme;
	logic [WAKE_CW-1:0] energy_cnt;
	logic               timing;

	// Event output level
	always_comb begin
		asserted = |(evt_ind_in & evt_en_in);
		hold_off = delay_en_in & auto_wake_in & ~clocks_ready_in;
		next_pme = polarity_in ? (asserted & ~hold_off) : ~(asserted & ~hold_off);
	end

	// Registered pin, idle high under default polarity
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pme_out <= 1'b1;
		end else begin
			pme_out <= next_pme;
		end
	end

	// Energy must persist while asleep in energy detect mode
	assign timing = auto_wake_in & wake_norm_in & low_power_in & energy_in
		& (pm_mode_in == PM_MODE_ENERGY);

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			energy_cnt   <= '0;
			wake_req_out <= 1'b0;
		end else begin
			wake_req_out <= 1'b0;
			if (!timing) begin
				energy_cnt <= '0;
			end else if (energy_cnt != WAKE_LAST) begin
				energy_cnt <= energy_cnt + 1'b1;
				wake_req_out <= (energy_cnt == WAKE_LAST - 1'b1);
			end
		end
	end

endmodule
`default_nettype wire

// *** testbench/gcr_host_model.sv ***
// Host processor model on the plain register port
`timescale 1ns/1ns
`default_nettype none
module gcr_host_model (
	input  wire logic        clock_in,
	output logic      [7:0]  addr_out,
	output logic      [15:0] wdata_out,
	output logic             wr_out,
	output logic             rd_out
);
	// Idle bus at time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end

	// One write cycle, data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'h1;
		@(posedge clock_in);
		wr_out <= 1'h0;
		wdata_out <= ~d;
		@(posedge clock_in);
	endtask

	// One read cycle, data stands in the next one
	task automatic rd(input logic [7:0] a);
		addr_out <= a;
		rd_out <= 1'h1;
		@(posedge clock_in);
		rd_out <= 1'h0;
		@(posedge clock_in);
	endtask
endmodule
`default_nettype wire

// *** testbench/gcr_regs_asserts.sv ***
// Port checks for the global control register bank
`timescale 1ns/1ns
`default_nettype none
module gcr_regs_asserts
	import gcr_pkg::*;
#(
	parameter int unsigned WAKE_CYC = WAKE_CYC_DFLT
) (
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_rdata_out,
	input  wire logic        mib_evt_valid_in,
	input  wire logic        mib_evt_ready_out,
	input  wire logic        full_dpx_in,
	input  wire logic        speed100_in,
	input  wire logic        port_led_zero_out,
	input  wire logic [3:0]  wake_evt_in,
	input  wire logic        energy_in,
	input  wire logic        low_power_in,
	input  wire logic        clocks_ready_in,
	input  wire logic        power_event_output_out,
	input  wire logic        wake_req_out
);
	logic [15:0] gcr;
	logic [15:0] pmec;
	logic        cmd_wr;
	logic        pm_wr;
	assign cmd_wr = reg_wr_in && reg_addr_in == OFS_IND_CMD;
	assign pm_wr  = reg_wr_in && reg_addr_in == OFS_PWR_EVT;

	// Shadow copies of control fields
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			gcr <= GCR_RST;
			pmec <= PMEC_RST;
		end else begin
			if (reg_wr_in && reg_addr_in == OFS_GLOBAL_CTRL) begin
				gcr <= reg_wdata_in;
			end
			if (pm_wr) begin
				pmec <= reg_wdata_in & PMEC_RW_MASK;
			end
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	////////////////////////////////////////////////////////////////////////
	property p_rd_idle; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_chip_id; reg_rd_in && reg_addr_in == OFS_CHIP_ID |=> reg_rdata_out == {FAMILY_ID, CHIP_ID, REV_ID, 1'h0};
	endproperty
	a_chip_id: assert property (p_chip_id) else $error("identification word wrong");
	property p_led0; !$past(sys_rst_in) && !$past(gcr[15])
		|-> port_led_zero_out == ($past(gcr[9]) ? $past(full_dpx_in) : $past(speed100_in)); endproperty
	a_led0: assert property (p_led0) else $error("lamp zero function wrong");
	property p_cmd; cmd_wr && reg_wdata_in[12:10] == 3'h7 |=> !mib_evt_ready_out [*2]; endproperty
	a_cmd: assert property (p_cmd) else $error("read command not launched");
	property p_noop; cmd_wr && !reg_wdata_in[12] && mib_evt_ready_out && !mib_evt_valid_in |=> mib_evt_ready_out;
	endproperty
	a_noop: assert property (p_noop) else $error("disabled command did work");
	property p_tsel; cmd_wr && reg_wdata_in[11:10] != TSEL_MIB && mib_evt_ready_out && !mib_evt_valid_in
		|=> mib_evt_ready_out; endproperty
	a_tsel: assert property (p_tsel) else $error("reserved table code did work");
	property p_take; mib_evt_valid_in && mib_evt_ready_out |=> !mib_evt_ready_out; endproperty
	a_take: assert property (p_take) else $error("counter update not taken");
	property p_pme_idle; !$past(sys_rst_in) && $past(pmec[11:8]) == 4'h0
		|-> power_event_output_out == !$past(pmec[12]); endproperty
	a_pme_idle: assert property (p_pme_idle) else $error("event pin active level wrong");
	property p_pme_evt; |(wake_evt_in & pmec[11:8]) && !pmec[14] && !pm_wr
		|-> ##2 power_event_output_out == $past(pmec[12], 2); endproperty
	a_pme_evt: assert property (p_pme_evt) else $error("enabled event not signalled");
	property p_pme_dly; !$past(sys_rst_in) && $past(pmec[14] && pmec[7] && !clocks_ready_in)
		|-> power_event_output_out == !$past(pmec[12]); endproperty
	a_pme_dly: assert property (p_pme_dly) else $error("event pin not held off");
	property p_wake; wake_req_out |-> $past(energy_in && low_power_in) ##1 !wake_req_out; endproperty
	a_wake: assert property (p_wake) else $error("wake request malformed");
endmodule
bind gcr_regs gcr_regs_asserts #(.WAKE_CYC(WAKE_CYC)) gcr_regs_asserts_inst (.*);
`default_nettype wire

// *** testbench/test_global_ctrl_mib_pme_regs.sv ***
// Self-checking bench for the global control register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_global_ctrl_mib_pme_regs
	import gcr_pkg::*;
;
	localparam int unsigned WCYC = 20;
	logic        clock_in;
	logic        sys_rst_in;
	logic        por_rst;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        ev_valid;
	logic [4:0]  ev_index;
	logic        ev_ready;
	logic [4:0]  phy;
	logic [3:0]  led;
	logic [3:0]  wake_evt;
	logic        energy;
	logic        low_pwr;
	logic        clk_rdy;
	logic        pme;
	logic        wake_req;
	logic        irq;
	logic        rd_seen;
	logic [15:0] exp_q[$];
	logic [15:0] exp_v;
	logic [15:0] v;
	logic [4:0]  a;
	int          n;
	int          wake_n;
	int          fail_count;
	int          checks_done;
	int unsigned seed;

	gcr_host_model gcr_host_model_inst (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd));
	gcr_regs #(.WAKE_CYC(WCYC)) gcr_regs_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .por_rst_in(por_rst),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.mib_evt_valid_in(ev_valid), .mib_evt_index_in(ev_index), .mib_evt_ready_out(ev_ready),
		.link_in(phy[4]), .act_in(phy[3]), .full_dpx_in(phy[2]), .col_in(phy[1]), .speed100_in(phy[0]),
		.port_led_three_out(led[3]), .port_led_two_out(led[2]), .port_led_one_out(led[1]),
		.port_led_zero_out(led[0]), .wake_evt_in(wake_evt), .energy_in(energy), .low_power_in(low_pwr),
		.clocks_ready_in(clk_rdy), .power_event_output_out(pme), .wake_req_out(wake_req), .irq_out(irq));

	// Free-running clock
	initial begin
		clock_in = 1'h0;
		forever #5 clock_in = ~clock_in;
	end

	// Read data compared in the cycle after the strobe
	always @(posedge clock_in) rd_seen <= rd;
	always @(negedge clock_in) begin
		if (rd_seen === 1'h1) begin
			exp_v = exp_q.pop_front();
			`CHK(rdata, exp_v)
		end
	end

	// Wake request pulse count
	always @(posedge clock_in) begin
		if (wake_req === 1'h1) begin
			wake_n <= wake_n + 1;
		end
	end

	// Note an expected word, then read it
	task automatic rd_chk(input logic [7:0] ad, input logic [15:0] e);
		exp_q.push_back(e);
		gcr_host_model_inst.rd(ad);
	endtask

	// Settled pin compare: 0 irq, 1 event pin
	task automatic pin_chk(input int i, input logic e);
		logic [1:0] p;
		@(negedge clock_in);
		p = {pme, irq};
		`CHK(p[i], e)
		@(posedge clock_in);
	endtask

	// Counter increments under handshake
	task automatic bump(input logic [4:0] ix, input int cnt);
		repeat (cnt) begin
			ev_valid <= 1'h1;
			ev_index <= ix;
			do @(posedge clock_in); while (ev_ready !== 1'h1);
			ev_valid <= 1'h0;
			ev_index <= ~ix;
			@(posedge clock_in);
		end
	endtask

	// Lamp pattern expected for each selection
	function automatic logic [3:0] led_exp(input int s, input logic [4:0] p);
		logic la;
		la = p[4] & ~p[3];
		case (s)
			0: led_exp = {1'h0, la, p[2] | p[1], p[0]};
			1: led_exp = {1'h0, la & p[0], la & ~p[0], p[2]};
			2: led_exp = {p[3], p[4], p[2] | p[1], p[0]};
			default: led_exp = 4'h0;
		endcase
	endfunction

	// One-cycle wake event
	task automatic pulse(input logic [3:0] e);
		wake_evt <= e;
		@(posedge clock_in);
		wake_evt <= 4'h0;
		@(posedge clock_in);
	endtask

	task automatic test_done;
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (3000) @(posedge clock_in);
		fail_count++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst_in, por_rst, ev_valid, energy, low_pwr, clk_rdy} = 6'h30;
		{ev_index, phy, wake_evt} = 14'h0000;
		{wake_n, fail_count, checks_done} = 0;
		seed = $urandom(68654);
		repeat (10) @(posedge clock_in);
		sys_rst_in <= 1'h0;
		por_rst <= 1'h0;
		@(posedge clock_in);
		// Reset values, identity, unmapped space
		rd_chk(OFS_CHIP_ID, {FAMILY_ID, CHIP_ID, REV_ID, 1'h0});
		gcr_host_model_inst.wr(OFS_CHIP_ID, 16'($urandom) & 16'hFFFE);
		rd_chk(OFS_CHIP_ID, {FAMILY_ID, CHIP_ID, REV_ID, 1'h0});
		rd_chk(8'hC2, 16'h0000);
		rd_chk(OFS_IND_CMD, IAC_RST);
		rd_chk(OFS_DATA_LO, DATA_RST);
		rd_chk(OFS_PWR_EVT, PMEC_RST);
		v = 16'($urandom);
		gcr_host_model_inst.wr(OFS_DATA_HI, v);
		rd_chk(OFS_DATA_HI, v);
		// Each lamp selection with random line status
		rd_chk(OFS_GLOBAL_CTRL, GCR_RST);
		for (int k = 0; k < 4; k++) begin
			v = 16'($urandom);
			v[15] = k[1];
			v[9] = k[0];
			gcr_host_model_inst.wr(OFS_GLOBAL_CTRL, v);
			rd_chk(OFS_GLOBAL_CTRL, v);
			repeat (6) begin
				phy <= 5'($urandom);
				@(posedge clock_in);
				@(negedge clock_in);
				`CHK(led, led_exp(k, phy))
				@(posedge clock_in);
			end
		end
		// Counters by address; reserved codes and no-op leave them
		a = 5'($urandom);
		n = $urandom_range(6, 1);
		bump(a, n);
		bump(~a, 2);
		for (int k = 0; k < 3; k++) begin
			gcr_host_model_inst.wr(OFS_IND_CMD, {3'h0, 1'h1, 2'(k), 5'h00, a});
		end
		gcr_host_model_inst.wr(OFS_IND_CMD, {3'h0, 1'h0, TSEL_MIB, 5'h00, a});
		gcr_host_model_inst.wr(OFS_IND_CMD, {3'h0, 1'h1, TSEL_MIB, 5'h00, a});
		// Data words load on the edge of this wait
		@(posedge clock_in);
		// both words fetched before next command
		rd_chk(OFS_DATA_LO, 16'(n));
		rd_chk(OFS_DATA_HI, 16'h0000);
		pin_chk(0, 1'h0);
		gcr_host_model_inst.wr(OFS_IRQ_MASK, 16'h0001);
		pin_chk(0, 1'h1);
		rd_chk(OFS_IRQ_STAT, 16'h0001);
		gcr_host_model_inst.wr(OFS_IRQ_STAT, 16'h0001);
		pin_chk(0, 1'h0);
		gcr_host_model_inst.wr(OFS_IND_CMD, {3'h0, 1'h1, TSEL_MIB, 5'h00, ~a});
		@(posedge clock_in);
		rd_chk(OFS_DATA_LO, 16'h0002);
		rd_chk(OFS_DATA_HI, 16'h0000);
		gcr_host_model_inst.wr(OFS_IND_CMD, {3'h0, 1'h1, TSEL_MIB, 5'h00, a});
		@(posedge clock_in);
		rd_chk(OFS_DATA_LO, 16'h0000);
		// Enabled, disabled, cleared and delayed power events
		gcr_host_model_inst.wr(OFS_PWR_EVT, 16'h1800);
		pulse(4'h8);
		rd_chk(OFS_PWR_EVT, 16'h1820);
		pin_chk(1, 1'h1);
		gcr_host_model_inst.wr(OFS_PWR_EVT, 16'h1820);
		pin_chk(1, 1'h0);
		pulse(4'h1);
		rd_chk(OFS_PWR_EVT, 16'h1804);
		pin_chk(1, 1'h0);
		sys_rst_in <= 1'h1;
		@(posedge clock_in);
		sys_rst_in <= 1'h0;
		@(posedge clock_in);
		rd_chk(OFS_PWR_EVT, 16'h0004);
		gcr_host_model_inst.wr(OFS_PWR_EVT, 16'h4180);
		pin_chk(1, 1'h1);
		gcr_host_model_inst.wr(OFS_PWR_EVT, 16'h4100);
		pin_chk(1, 1'h0);
		gcr_host_model_inst.wr(OFS_PWR_EVT, 16'h4180);
		clk_rdy <= 1'h1;
		@(posedge clock_in);
		pin_chk(1, 1'h0);
		// Short energy run, drop, then a full one
		gcr_host_model_inst.wr(OFS_PWR_EVT, 16'h00C1);
		low_pwr <= 1'h1;
		energy <= 1'h1;
		repeat (WCYC - 5) @(posedge clock_in);
		energy <= 1'h0;
		@(posedge clock_in);
		energy <= 1'h1;
		repeat (WCYC + 10) @(posedge clock_in);
		`CHK(wake_n, 1)
		test_done;
	end
endmodule
`default_nettype wire
